//--- inc/crs_pkg.sv
// Purpose: constants, types and register map of the cpu register set
// Assumes: 10 MHz sys_clk, 32-bit Avalon-MM register window
// Notes: byte addresses on the bus; data-space addresses are 16 bits
package crs_pkg;
  localparam int unsigned CLK_HZ = 10_000_000;
  // data space map
  localparam logic [15:0] RST_VEC_LO = 16'h0000;
  localparam logic [15:0] RST_VEC_HI = 16'h0001;
  localparam logic [15:0] HSRAM_LO = 16'hFB00;
  localparam logic [15:0] HSRAM_HI = 16'hFEFF;
  localparam logic [15:0] GREG_LO = 16'hFEE0;
  localparam logic [15:0] GREG_HI = 16'hFEFF;
  localparam logic [15:0] SFR_LO = 16'hFF00;
  localparam logic [15:0] SFR_HI = 16'hFFFF;
  localparam logic [15:0] LCD_LO = 16'hFA64;
  localparam logic [15:0] LCD_HI = 16'hFA7F;
  localparam logic [15:0] EXP_LO = 16'hF600;
  localparam logic [15:0] EXP_HI = 16'hF7DF;
  localparam int unsigned GREG_NUM = 32;
  localparam int unsigned LCD_NUM = 28;
  // status word
  localparam logic [7:0] PSW_RESET = 8'h02;
  localparam int unsigned PSW_INT_EN = 7;
  localparam int unsigned PSW_Z = 6;
  localparam int unsigned PSW_BANK_HI = 5;
  localparam int unsigned PSW_HALF = 4;
  localparam int unsigned PSW_BANK_LO = 3;
  localparam int unsigned PSW_PRIO = 1;
  localparam int unsigned PSW_CARRY = 0;
  // bus map, word index = byte address / 4
  localparam int unsigned AVS_AW = 9;
  localparam logic [6:0] IDX_PC = 7'h00;
  localparam logic [6:0] IDX_PSW = 7'h01;
  localparam logic [6:0] IDX_SP = 7'h02;
  localparam logic [6:0] IDX_CMD = 7'h03;
  localparam logic [6:0] IDX_STATUS = 7'h04;
  localparam logic [6:0] IDX_GREG = 7'h20;
  localparam logic [6:0] IDX_LCD = 7'h40;
  localparam int unsigned CMD_INT_EN = 0;
  localparam int unsigned CMD_INT_DIS = 1;
  localparam int unsigned CMD_CLR = 2;
  localparam int unsigned ST_STACK = 0;
  localparam int unsigned ST_FETCH = 1;
  localparam int unsigned ST_ALIGN = 2;
  localparam int unsigned ST_READY = 3;

  typedef enum logic [2:0] {
    REG_OTHER, REG_EXP, REG_LCD, REG_HSRAM, REG_GREG, REG_SFR
  } crs_region_e;
  typedef enum logic [1:0] {ACC_BIT, ACC_BYTE, ACC_WORD} crs_width_e;

  typedef struct packed {
    logic pc_adv;
    logic [2:0] pc_len;
    logic pc_load;
    logic [15:0] pc_target;
    logic alu_we;
    logic [7:0] alu_result;
    logic alu_half;
    logic alu_carry;
    logic carry_we;
    logic carry_val;
    logic int_en_set;
    logic int_en_clr;
    logic int_ack;
    logic bank_we;
    logic [1:0] bank;
    logic push;
    logic push_psw;
    logic [7:0] push_data;
    logic pop;
    logic psw_restore;
    logic [7:0] restore_data;
    logic gr_we;
    logic gr_pair;
    logic [2:0] gr_idx;
    logic [15:0] gr_wdata;
  } crs_core_req_s;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [15:0] addr;
    logic [7:0] wdata;
  } crs_stack_s;

  typedef struct packed {
    logic req;
    logic wr;
    logic [15:0] addr;
    crs_width_e width;
  } crs_sfr_s;
endpackage

//--- logic/crs_regset.sv
// Purpose: program counter, status word, stack pointer, general register
//   banks, display buffer and data-space decode of an 8-bit core
// Assumes: vector memory answers one cycle after mem_rd; core ops only
//   while core_ready; inputs synchronous to sys_clk
// Notes: Avalon-MM slave answers every access after one wait cycle
// Notes on behaviour
// - 16-bit pc advances by instruction length, or loads a branch target
// - reset loads pc from the vector bytes at 0000H and 0001H
// - vector low byte from even address, high byte from odd address
// - status word is 8 flag bits, reset value 02H
// - status word stacked on interrupt or push, restored by returns and pop
// - enable flag low blocks all but non-maskable; high defers to priority, masks
// - enable flag cleared by disable instruction or acknowledge, set by enable instruction
// - zero flag set on zero result, cleared otherwise
// - two bank-select bits pick one of four banks, written by bank switch
// - half carry set on carry out of or borrow into bit 3
// - priority flag low blocks acknowledgement of low-priority maskable interrupts
// - carry takes add/subtract overflow, rotate shift-out, bit accumulator
// - 16-bit stack pointer; stack only inside high-speed ram; accesses outside still happen and only set the stack fault bit
// - high-speed ram spans FB00H to FEFFH, 1024 bytes
// - sp decremented before a stack write, incremented after a read
// - general registers at FEE0H-FEFFH, four banks of eight bytes
// - adjacent registers also form four 16-bit pairs
// - special function registers decoded in FF00H-FFFFH
// - sfr accesses use their widths; 16-bit accesses need even address
// - writes to read-only registers ignored; write-only reads return nothing
// - 28 x 4-bit display buffer at FA64H-FA7FH, also usable as ram
// - no instruction fetch from expansion ram F600H-F7DFH
// - data space spans the full 64K bytes, 0000H-FFFFH
//
// The Avalon-MM interface to the registers and the placing of the registers were decided locally.
`timescale 1ns/1ns
module crs_regset
  import crs_pkg::*;
(
  input wire logic sys_clk,
  input wire logic reset_n,
  input wire logic clk_en,
  // register bus
  input wire logic [crs_pkg::AVS_AW-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // reset vector fetch
  output logic mem_rd,
  output logic [15:0] mem_addr,
  input wire logic [7:0] mem_rdata,
  // core side
  input wire crs_pkg::crs_core_req_s core_req,
  output logic core_ready,
  output logic [15:0] pc,
  output logic [7:0] program_status_word,
  output logic [15:0] sp,
  output logic [15:0] gr_rdata,
  output crs_pkg::crs_stack_s stack_op,
  // interrupt acceptance
  input wire logic irq_nmi,
  input wire logic irq_pending,
  input wire logic irq_low_prio,
  output logic irq_accept,
  // data-space port
  input wire logic [15:0] data_addr,
  input wire logic data_wr,
  input wire logic [7:0] data_wdata,
  output logic [7:0] data_rdata,
  output crs_pkg::crs_region_e data_region,
  // fetch and sfr checks
  input wire logic [15:0] fetch_addr,
  input wire logic fetch_req,
  output logic fetch_denied,
  input wire crs_pkg::crs_sfr_s sfr_acc,
  output logic sfr_sel,
  output logic sfr_misalign
);
  import crs_pkg::*;
  typedef enum logic [1:0] {VEC_LO, VEC_HI, VEC_LOAD, RUN} crs_boot_e;
  crs_boot_e boot_r;
  logic [7:0] vec_lo_r;
  logic [15:0] pc_r;
  logic [7:0] psw_r;
  logic [7:0] psw_nxt;
  logic [15:0] sp_r;
  logic [7:0] greg_r [GREG_NUM];
  logic [3:0] lcd_r [LCD_NUM];
  logic [2:0] status_r;
  logic ack_r;
  logic [31:0] rdata_r;
  logic [6:0] idx;
  logic bus_wr;
  logic bus_rd;
  logic run;
  logic [1:0] bank;
  logic [4:0] gr_base;
  logic [4:0] dgr_idx;
  logic [4:0] dlcd_idx;
  logic [4:0] bgr_idx;
  logic [4:0] blcd_idx;
  logic data_in_gr;
  logic data_in_lcd;
  logic bus_in_gr;
  logic bus_in_lcd;
  logic stack_bad;
  logic [15:0] push_addr;

  assign idx = avs_address[AVS_AW-1:2];
  assign bus_wr = avs_write && ack_r;
  assign bus_rd = avs_read && !ack_r;
  assign avs_waitrequest = (avs_read || avs_write) && !ack_r;
  assign avs_readdata = rdata_r;
  assign run = (boot_r == RUN);
  assign core_ready = run;
  assign pc = pc_r;
  assign program_status_word = psw_r;
  assign sp = sp_r;
  assign bank = {psw_r[PSW_BANK_HI], psw_r[PSW_BANK_LO]};

  // bank 0 sits at the top, bank 3 at the bottom
  assign gr_base = {~bank, 3'b000};
  assign data_in_gr = (data_addr >= GREG_LO) && (data_addr <= GREG_HI);
  assign data_in_lcd = (data_addr >= LCD_LO) && (data_addr <= LCD_HI);
  assign dgr_idx = data_addr[4:0];
  assign dlcd_idx = 5'(data_addr - LCD_LO);
  assign bus_in_gr = (idx >= IDX_GREG) && (idx < IDX_GREG + 7'(GREG_NUM));
  assign bus_in_lcd = (idx >= IDX_LCD) && (idx < IDX_LCD + 7'(LCD_NUM));
  assign bgr_idx = 5'(idx - IDX_GREG);
  assign blcd_idx = 5'(idx - IDX_LCD);

  // bus handshake: one wait cycle, data captured while waiting
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      ack_r <= 1'b0;
    end else if (clk_en) begin
      ack_r <= (avs_read || avs_write) && !ack_r;
    end
  end

  // write-only command word reads as zero
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      rdata_r <= 32'h0000_0000;
    end else if (clk_en && bus_rd) begin
      rdata_r <= 32'h0000_0000;
      if (idx == IDX_PC) begin
        rdata_r <= {16'h0000, pc_r};
      end else if (idx == IDX_PSW) begin
        rdata_r <= {24'h00_0000, psw_r};
      end else if (idx == IDX_SP) begin
        rdata_r <= {16'h0000, sp_r};
      end else if (idx == IDX_STATUS) begin
        rdata_r <= {26'h000_0000, bank, run, status_r};
      end else if (bus_in_gr) begin
        rdata_r <= {24'h00_0000, greg_r[bgr_idx]};
      end else if (bus_in_lcd) begin
        rdata_r <= {28'h000_0000, lcd_r[blcd_idx]};
      end
    end
  end

  // boot sequence fetches the reset vector
  assign mem_rd = (boot_r == VEC_LO) || (boot_r == VEC_HI);
  assign mem_addr = (boot_r == VEC_HI) ? RST_VEC_HI : RST_VEC_LO;
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      boot_r <= VEC_LO;
      vec_lo_r <= 8'h00;
    end else if (clk_en) begin
      unique case (boot_r)
        VEC_LO: boot_r <= VEC_HI;
        VEC_HI: begin
          vec_lo_r <= mem_rdata;
          boot_r <= VEC_LOAD;
        end
        VEC_LOAD: boot_r <= RUN;
        RUN: boot_r <= RUN;
      endcase
    end
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      pc_r <= 16'h0000;
    end else if (clk_en) begin
      if (boot_r == VEC_LOAD) begin
        pc_r <= {mem_rdata, vec_lo_r};
      end else if (run && core_req.pc_load) begin
        pc_r <= core_req.pc_target;
      end else if (run && core_req.pc_adv) begin
        pc_r <= pc_r + 16'(core_req.pc_len);
      end else if (bus_wr && idx == IDX_PC && avs_byteenable[1:0] == 2'b11) begin
        pc_r <= avs_writedata[15:0];
      end
    end
  end

  // status word: restore wins, then hardware flags over software write
  always_comb begin
    psw_nxt = psw_r;
    if (bus_wr && idx == IDX_PSW && avs_byteenable[0]) begin
      psw_nxt = avs_writedata[7:0];
    end
    if (bus_wr && idx == IDX_CMD && avs_writedata[CMD_INT_EN]) begin
      psw_nxt[PSW_INT_EN] = 1'b1;
    end
    if (bus_wr && idx == IDX_CMD && avs_writedata[CMD_INT_DIS]) begin
      psw_nxt[PSW_INT_EN] = 1'b0;
    end
    if (run) begin
      if (core_req.alu_we) begin
        psw_nxt[PSW_Z] = (core_req.alu_result == 8'h00);
        psw_nxt[PSW_HALF] = core_req.alu_half;
        psw_nxt[PSW_CARRY] = core_req.alu_carry;
      end
      if (core_req.carry_we) begin
        psw_nxt[PSW_CARRY] = core_req.carry_val;
      end
      if (core_req.bank_we) begin
        psw_nxt[PSW_BANK_HI] = core_req.bank[1];
        psw_nxt[PSW_BANK_LO] = core_req.bank[0];
      end
      if (core_req.int_en_set) begin
        psw_nxt[PSW_INT_EN] = 1'b1;
      end
      if (core_req.int_en_clr || core_req.int_ack) begin
        psw_nxt[PSW_INT_EN] = 1'b0;
      end
      if (core_req.psw_restore) begin
        psw_nxt = core_req.restore_data;
      end
    end
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      psw_r <= PSW_RESET;
    end else if (clk_en) begin
      psw_r <= psw_nxt;
    end
  end

  // interrupt acceptance gate
  assign irq_accept = run && (irq_nmi || (psw_r[PSW_INT_EN] && irq_pending
    && (psw_r[PSW_PRIO] || !irq_low_prio)));

  // stack: pre-decrement on push, post-increment on pop
  assign push_addr = sp_r - 16'h0001;
  always_comb begin
    stack_op.wr = run && (core_req.push || core_req.push_psw || core_req.int_ack);
    stack_op.rd = run && core_req.pop && !stack_op.wr;
    stack_op.addr = stack_op.wr ? push_addr : sp_r;
    stack_op.wdata = core_req.push ? core_req.push_data : psw_r;
  end
  assign stack_bad = stack_op.wr ? (push_addr < HSRAM_LO || push_addr > HSRAM_HI)
    : (stack_op.rd && (sp_r < HSRAM_LO || sp_r > HSRAM_HI));

  // sp has no reset value of meaning; zero keeps simulation clean
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      sp_r <= 16'h0000;
    end else if (clk_en) begin
      if (stack_op.wr) begin
        sp_r <= push_addr;
      end else if (stack_op.rd) begin
        sp_r <= sp_r + 16'h0001;
      end else if (bus_wr && idx == IDX_SP && avs_byteenable[1:0] == 2'b11) begin
        sp_r <= avs_writedata[15:0];
      end
    end
  end

  // general registers, one generate branch per byte
  genvar g;
  generate
    for (g = 0; g < GREG_NUM; g++) begin : gen_greg
      always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
          greg_r[g] <= 8'h00;
        end else if (clk_en) begin
          if (run && core_req.gr_we && core_req.gr_pair
              && 5'(g) == {gr_base[4:3], core_req.gr_idx[1:0], 1'b0}) begin
            greg_r[g] <= core_req.gr_wdata[7:0];
          end else if (run && core_req.gr_we && core_req.gr_pair
              && 5'(g) == {gr_base[4:3], core_req.gr_idx[1:0], 1'b1}) begin
            greg_r[g] <= core_req.gr_wdata[15:8];
          end else if (run && core_req.gr_we && !core_req.gr_pair
              && 5'(g) == (gr_base | 5'(core_req.gr_idx))) begin
            greg_r[g] <= core_req.gr_wdata[7:0];
          end else if (data_wr && data_in_gr && dgr_idx == 5'(g)) begin
            greg_r[g] <= data_wdata;
          end else if (bus_wr && bus_in_gr && bgr_idx == 5'(g) && avs_byteenable[0]) begin
            greg_r[g] <= avs_writedata[7:0];
          end
        end
      end
    end
    for (g = 0; g < LCD_NUM; g++) begin : gen_lcd
      always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
          lcd_r[g] <= 4'h0;
        end else if (clk_en) begin
          if (data_wr && data_in_lcd && dlcd_idx == 5'(g)) begin
            lcd_r[g] <= data_wdata[3:0];
          end else if (bus_wr && bus_in_lcd && blcd_idx == 5'(g) && avs_byteenable[0]) begin
            lcd_r[g] <= avs_writedata[3:0];
          end
        end
      end
    end
  endgenerate

  assign gr_rdata = core_req.gr_pair
    ? {greg_r[{gr_base[4:3], core_req.gr_idx[1:0], 1'b1}],
       greg_r[{gr_base[4:3], core_req.gr_idx[1:0], 1'b0}]}
    : {8'h00, greg_r[gr_base | 5'(core_req.gr_idx)]};

  // full 64K decode of the data space
  always_comb begin
    data_region = REG_OTHER;
    data_rdata = 8'h00;
    if (data_addr >= SFR_LO) begin
      data_region = REG_SFR;
    end else if (data_in_gr) begin
      data_region = REG_GREG;
      data_rdata = greg_r[dgr_idx];
    end else if (data_addr >= HSRAM_LO) begin
      data_region = REG_HSRAM;
    end else if (data_in_lcd) begin
      data_region = REG_LCD;
      data_rdata = {4'h0, lcd_r[dlcd_idx]};
    end else if (data_addr >= EXP_LO && data_addr <= EXP_HI) begin
      data_region = REG_EXP;
    end
  end

  assign fetch_denied = fetch_req && fetch_addr >= EXP_LO && fetch_addr <= EXP_HI;
  assign sfr_sel = sfr_acc.req && sfr_acc.addr >= SFR_LO && sfr_acc.addr <= SFR_HI;
  assign sfr_misalign = sfr_sel && sfr_acc.width == ACC_WORD && sfr_acc.addr[0];

  // sticky faults: a new event wins over a clear; status is read-only
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      status_r <= 3'b000;
    end else if (clk_en) begin
      if (bus_wr && idx == IDX_CMD && avs_writedata[CMD_CLR]) begin
        status_r <= 3'b000;
      end
      if (stack_bad) begin
        status_r[ST_STACK] <= 1'b1;
      end
      if (fetch_denied) begin
        status_r[ST_FETCH] <= 1'b1;
      end
      if (sfr_misalign) begin
        status_r[ST_ALIGN] <= 1'b1;
      end
    end
  end

  a_pc_advance: assert property (@(posedge sys_clk) disable iff (!reset_n)
    clk_en && run && core_req.pc_adv && !core_req.pc_load
    |=> pc_r == $past(pc_r) + 16'($past(core_req.pc_len)))
    else $error("pc did not advance by instruction length");
  a_pc_branch: assert property (@(posedge sys_clk) disable iff (!reset_n)
    clk_en && run && core_req.pc_load |=> pc_r == $past(core_req.pc_target))
    else $error("pc did not take branch target");
  a_vec_load: assert property (@(posedge sys_clk) disable iff (!reset_n)
    clk_en && boot_r == VEC_HI ##1 clk_en && boot_r == VEC_LOAD
    |=> pc_r == {$past(mem_rdata), $past(mem_rdata, 2)})
    else $error("reset vector bytes assembled wrongly");
  a_ie_ack: assert property (@(posedge sys_clk) disable iff (!reset_n)
    clk_en && run && core_req.int_ack && !core_req.psw_restore |=> !psw_r[PSW_INT_EN])
    else $error("enable flag not cleared on acknowledge");
  a_irq_gate: assert property (@(posedge sys_clk) disable iff (!reset_n)
    irq_accept && !irq_nmi |-> psw_r[PSW_INT_EN] && (psw_r[PSW_PRIO] || !irq_low_prio))
    else $error("maskable interrupt accepted while blocked");
  a_zero_flag: assert property (@(posedge sys_clk) disable iff (!reset_n)
    clk_en && run && core_req.alu_we && !core_req.psw_restore
    |=> psw_r[PSW_Z] == ($past(core_req.alu_result) == 8'h00))
    else $error("zero flag mismatch");
  a_stack_push: assert property (@(posedge sys_clk) disable iff (!reset_n)
    clk_en && stack_op.wr |-> stack_op.addr == sp_r - 16'h0001
    ##1 sp_r == $past(sp_r) - 16'h0001)
    else $error("push not pre-decremented");
  a_stack_pop: assert property (@(posedge sys_clk) disable iff (!reset_n)
    clk_en && stack_op.rd |-> stack_op.addr == sp_r ##1 sp_r == $past(sp_r) + 16'h0001)
    else $error("pop not post-incremented");
  a_bank_map: assert property (@(posedge sys_clk) disable iff (!reset_n)
    clk_en && run && core_req.gr_we && !core_req.gr_pair && !data_wr && bank == 2'b00
    |=> greg_r[5'h18 | 5'($past(core_req.gr_idx))] == $past(core_req.gr_wdata[7:0]))
    else $error("bank 0 register not at top of window");
  a_fetch_deny: assert property (@(posedge sys_clk) disable iff (!reset_n)
    clk_en && fetch_denied |=> status_r[ST_FETCH])
    else $error("denied fetch not recorded");
  a_status_ro: assert property (@(posedge sys_clk) disable iff (!reset_n)
    clk_en && bus_wr && idx == IDX_STATUS && !stack_bad && !fetch_denied && !sfr_misalign
    |=> status_r == $past(status_r))
    else $error("write to read-only status changed it");
endmodule

//--- tb/crs_tb.sv
// Purpose: self-checking bench for the cpu register set
// Assumes: one wait cycle per bus access, vector bytes answered a cycle late
// Notes: bus walk, stack, flags, banks, data-space decode
`timescale 1ns/1ns
module tb;
  import crs_pkg::*;
  logic sys_clk;
  logic reset_n;
  logic clk_en;
  logic [8:0] avs_address;
  logic avs_read;
  logic avs_write;
  logic [31:0] avs_writedata;
  logic [3:0] avs_byteenable;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  logic mem_rd;
  logic [15:0] mem_addr;
  logic [7:0] mem_rdata;
  crs_core_req_s core_req;
  logic core_ready;
  logic [15:0] pc;
  logic [7:0] program_status_word;
  logic [15:0] sp;
  logic [15:0] gr_rdata;
  crs_stack_s stack_op;
  logic irq_nmi;
  logic irq_pending;
  logic irq_low_prio;
  logic irq_accept;
  logic [15:0] data_addr;
  logic data_wr;
  logic [7:0] data_wdata;
  logic [7:0] data_rdata;
  crs_region_e data_region;
  logic [15:0] fetch_addr;
  logic fetch_req;
  logic fetch_denied;
  crs_sfr_s sfr_acc;
  logic sfr_sel;
  logic sfr_misalign;
  int mismatches = 0;
  int checked = 0;
  int cyc = 0;
  logic [7:0] lfsr;
  logic [7:0] lo;
  logic [7:0] hi;
  logic [31:0] q;
  logic [15:0] esp;
  logic [7:0] d0;
  logic [7:0] d1;
  logic [15:0] epc;
  crs_core_req_s r;
  logic [15:0] ta [7] = '{16'hF5FF, 16'hF600, 16'hF7DF, 16'hFA7F, 16'hFB00, 16'hFEFF, 16'hFF00};
  crs_region_e tr [7] = '{REG_OTHER, REG_EXP, REG_EXP, REG_LCD, REG_HSRAM, REG_GREG, REG_SFR};

  crs_regset u_dut (.*);

  initial begin
    sys_clk = 1'b0;
    forever #50 sys_clk = ~sys_clk;
  end

  // vector memory answers one cycle after the strobe
  always @(posedge sys_clk) begin
    if (mem_rd) mem_rdata <= mem_addr[0] ? hi : lo;
    cyc <= cyc + 1;
    if (cyc == 6000) begin
      mismatches++;
      conclude();
    end
  end

  function automatic logic [7:0] rnd();
    lfsr = {lfsr[6:0], lfsr[7] ^ lfsr[5] ^ lfsr[4] ^ lfsr[3]};
    return lfsr;
  endfunction

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    checked++;
    if (got !== exp) begin
      mismatches++;
      $display("[ERR] %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  task automatic bus(input logic rd, input logic [8:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    avs_address <= a;
    avs_writedata <= d;
    avs_read <= rd;
    avs_write <= !rd;
    // request held until an edge samples waitrequest low
    do begin
      @(posedge sys_clk);
    end while (avs_waitrequest !== 1'b0);
    q = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask

  task automatic op(input crs_core_req_s c);
    @(posedge sys_clk);
    core_req <= c;
    @(negedge sys_clk);
  endtask

  task automatic conclude();
    $display("counts: checked %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  initial begin
    reset_n = 1'b0;
    clk_en = 1'b1;
    avs_address = '0;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = '0;
    avs_byteenable = 4'hF;
    mem_rdata = '0;
    core_req = '0;
    {irq_nmi, irq_pending, irq_low_prio} = 3'h0;
    {data_addr, data_wr, data_wdata, fetch_addr, fetch_req} = '0;
    sfr_acc = '0;
    lfsr = 8'h1A;
    lo = rnd();
    hi = rnd();
    repeat (8) @(posedge sys_clk);
    reset_n <= 1'b1;
    for (int i = 0; i < 20 && core_ready !== 1'b1; i++) @(negedge sys_clk);
    chk(pc, {hi, lo}, "reset pc");
    chk(program_status_word, 8'h02, "reset psw");
    $display("test reset done");
    esp = 16'hFE20;
    bus(1'b0, 9'h008, esp);
    bus(1'b1, 9'h008, 0);
    chk(q, esp, "sp rw");
    d0 = rnd();
    d1 = rnd();
    bus(1'b0, 9'h000, {d1, d0});
    bus(1'b1, 9'h000, 0);
    chk(q, {d1, d0}, "pc rw");
    epc = {d1, d0};
    bus(1'b1, 9'h01C, 0);
    chk(q, 0, "unmapped");
    $display("test bus done");
    r = '0;
    r.push = 1'b1;
    r.push_data = rnd();
    op(r);
    chk({stack_op.wr, stack_op.addr, stack_op.wdata}, {1'b1, esp - 16'h1, r.push_data}, "push");
    op('0);
    esp = esp - 16'h1;
    chk(sp, esp, "sp dec");
    r = '0;
    r.pop = 1'b1;
    op(r);
    chk({stack_op.rd, stack_op.addr}, {1'b1, esp}, "pop");
    op('0);
    esp = esp + 16'h1;
    chk(sp, esp, "sp inc");
    $display("test stack done");
    r = '0;
    r.int_en_set = 1'b1;
    op(r);
    @(posedge sys_clk);
    irq_pending <= 1'b1;
    core_req <= '0;
    @(negedge sys_clk);
    chk(irq_accept, 1, "accept enabled");
    r = '0;
    r.int_ack = 1'b1;
    op(r);
    op('0);
    chk({program_status_word[7], irq_accept}, 2'b00, "ack clears enable");
    @(posedge sys_clk);
    irq_nmi <= 1'b1;
    @(negedge sys_clk);
    chk(irq_accept, 1, "nmi");
    @(posedge sys_clk);
    irq_nmi <= 1'b0;
    irq_low_prio <= 1'b1;
    bus(1'b0, 9'h004, 32'h80);
    @(negedge sys_clk);
    chk(irq_accept, 0, "priority flag low");
    r = '0;
    r.int_en_clr = 1'b1;
    op(r);
    op('0);
    chk(program_status_word[7], 0, "disable");
    $display("test irq done");
    for (int k = 0; k < 4; k++) begin
      r = '0;
      r.alu_we = 1'b1;
      r.alu_result = k[0] ? 8'h00 : (rnd() | 8'h01);
      r.alu_half = k[1];
      r.alu_carry = k[0] ^ k[1];
      op(r);
      op('0);
      chk({program_status_word[6], program_status_word[4], program_status_word[0]}, {k[0], k[1], k[0] ^ k[1]}, "flags");
    end
    for (int b = 0; b < 4; b++) begin
      d0 = rnd();
      d1 = rnd();
      bus(1'b0, 9'(32'h80 + (3 - b) * 32), {24'h0, d0});
      bus(1'b0, 9'(32'h84 + (3 - b) * 32), {24'h0, d1});
      r = '0;
      r.bank_we = 1'b1;
      r.bank = 2'(b);
      op(r);
      r = '0;
      r.gr_pair = 1'b1;
      op(r);
      chk({program_status_word[5], program_status_word[3]}, b, "bank");
      chk(gr_rdata, {d1, d0}, "pair");
      @(posedge sys_clk);
      data_addr <= 16'(32'hFEE0 + (3 - b) * 8);
      @(negedge sys_clk);
      chk(data_rdata, d0, "greg map");
    end
    $display("test banks done");
    @(posedge sys_clk);
    data_addr <= LCD_LO;
    data_wdata <= rnd();
    data_wr <= 1'b1;
    @(posedge sys_clk);
    data_wr <= 1'b0;
    @(negedge sys_clk);
    chk(data_rdata[3:0], data_wdata[3:0], "lcd ram");
    for (int i = 0; i < 7; i++) begin
      @(posedge sys_clk);
      data_addr <= ta[i];
      fetch_addr <= ta[i];
      fetch_req <= 1'b1;
      @(negedge sys_clk);
      chk(data_region, tr[i], "region");
      chk(fetch_denied, (i == 1 || i == 2), "fetch");
    end
    @(posedge sys_clk);
    sfr_acc <= '{req: 1'b1, wr: 1'b0, addr: 16'hFF69, width: ACC_WORD};
    @(negedge sys_clk);
    chk({sfr_sel, sfr_misalign}, 2'b11, "odd word");
    @(posedge sys_clk);
    sfr_acc.addr <= 16'hFF68;
    @(negedge sys_clk);
    chk({sfr_sel, sfr_misalign}, 2'b10, "even word");
    $display("test decode done");
    bus(1'b0, 9'h010, 32'hFF);
    bus(1'b1, 9'h010, 0);
    chk(q, 32'h3E, "status ro");
    bus(1'b0, 9'h00C, 32'h5);
    @(negedge sys_clk);
    chk(program_status_word[7], 1, "cmd enable");
    bus(1'b0, 9'h00C, 32'h2);
    bus(1'b1, 9'h010, 0);
    chk(program_status_word[7], 0, "cmd disable");
    chk(q, 32'h38, "cmd clear");
    $display("test status done");
    r = '0;
    r.pc_adv = 1'b1;
    r.pc_len = 3'(rnd());
    op(r);
    op('0);
    epc = epc + 16'(r.pc_len);
    chk(pc, epc, "pc advance");
    r.pc_load = 1'b1;
    r.pc_target = {rnd(), rnd()};
    op(r);
    op('0);
    chk(pc, r.pc_target, "pc load");
    d0 = rnd();
    bus(1'b0, 9'h004, {24'h0, d0});
    bus(1'b0, 9'h008, 32'hFB00);
    r = '0;
    r.push_psw = 1'b1;
    op(r);
    chk({stack_op.wr, stack_op.addr, stack_op.wdata}, {1'b1, 16'hFAFF, d0}, "push psw");
    r = '0;
    r.psw_restore = 1'b1;
    r.restore_data = rnd() & 8'hD7;
    r.carry_we = 1'b1;
    r.carry_val = !r.restore_data[0];
    op(r);
    op('0);
    chk(program_status_word, r.restore_data, "restore");
    r.psw_restore = 1'b0;
    op(r);
    op('0);
    chk(program_status_word[0], r.carry_val, "carry");
    r = '0;
    r.gr_we = 1'b1;
    r.gr_idx = 3'(rnd());
    r.gr_wdata = {rnd(), rnd()};
    op(r);
    r.gr_we = 1'b0;
    op(r);
    chk(gr_rdata, {8'h00, r.gr_wdata[7:0]}, "core byte");
    @(posedge sys_clk);
    data_addr <= 16'hFEF8 | 16'(r.gr_idx);
    @(negedge sys_clk);
    chk(data_rdata, r.gr_wdata[7:0], "bank 0 top");
    bus(1'b1, 9'h010, 0);
    chk(q[3:0], 4'h9, "stack fault");
    $display("test core done");
    conclude();
  end
endmodule
